//--- irq_tb_pkg.sv
// Constants, field layouts and carrier types for the interrupt
// source collector and its two time-base generators.
// Assumes a 32-bit AXI4-Lite bus and a core on the same clock.
`default_nettype none

package irq_tb_pkg;

  // ********************************************************
  // Register map (byte addresses)
  // ********************************************************
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  OFF_TB0_CTRL = 8'h00;
  localparam logic [7:0]  OFF_TB1_CTRL = 8'h04;
  localparam logic [7:0]  OFF_CLK_SEL  = 8'h08;
  localparam logic [7:0]  OFF_ENABLE   = 8'h0c;
  localparam logic [7:0]  OFF_FLAGS    = 8'h10;
  localparam logic [7:0]  OFF_STATUS   = 8'h14;

  // ********************************************************
  // Time-base fields
  // ********************************************************
  localparam int          RUN_BIT      = 7;
  localparam int          PERIOD_LSB   = 0;
  localparam int          PERIOD_W     = 3;
  localparam int          SRC_W        = 2;
  localparam logic [7:0]  TB_CTRL_MASK = 8'h87;
  localparam logic [7:0]  CLK_SEL_MASK = 8'h03;
  localparam logic [7:0]  REG8_RESET   = 8'h00;
  localparam logic [1:0]  SRC_SYS      = 2'h0;
  localparam logic [1:0]  SRC_SYS_DIV4 = 2'h1;
  localparam logic [1:0]  SRC_SUB      = 2'h3;
  localparam logic [1:0]  DIV4_LAST    = 2'h3;
  localparam int          CNT_W        = 16;
  localparam logic [15:0] BASE_PERIOD  = 16'h0100;
  localparam logic [15:0] CNT_ONE      = 16'h0001;
  localparam logic [15:0] CNT_RESET    = 16'h0000;

  // ********************************************************
  // Flag and enable bit positions (vector order first)
  // ********************************************************
  localparam int B_DEMOD   = 0;
  localparam int B_CONV    = 1;
  localparam int B_TB0     = 2;
  localparam int B_TB1     = 3;
  localparam int B_GRP0    = 4;
  localparam int B_GRP1    = 5;
  localparam int B_GRP2    = 6;
  localparam int B_SERIAL  = 7;
  localparam int B_NVM     = 8;
  localparam int B_LV      = 9;
  localparam int B_TMR     = 10;
  localparam int B_TMR_TOP = 13;
  localparam int B_GLOBAL  = 15;
  localparam int N_TIMERS  = 2;
  localparam int VEC_W     = 8;
  localparam int FLAG_W    = 14;
  localparam int EN_W      = 16;
  localparam logic [13:0] FLAG_RESET = 14'h0000;
  localparam logic [15:0] EN_RESET   = 16'h0000;
  localparam logic [15:0] EN_MASK    = 16'hbfff;
  localparam logic [5:0]  NO_SRC_CLR = 6'h00;
  localparam logic [7:0]  VEC_NONE   = 8'h00;

  // ********************************************************
  // Bus answers
  // ********************************************************
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;

  typedef struct packed {
    logic       demod_done;
    logic       conv_done;
    logic       nvm_write_done;
    logic       low_voltage;
    logic       serial_byte_done;
    logic [1:0] timer_period_match;
    logic [1:0] timer_second_match;
  } src_events_t;

  typedef struct packed {
    logic       take;
    logic [7:0] sel;
  } vector_req_t;

endpackage : irq_tb_pkg

`default_nettype wire

//--- irq_sources_and_time_base.sv
// Interrupt request collector, vector decision and two time bases,
// with an AXI4-Lite register slave.
// Assumes event inputs and stack_full come from logic on aclk,
// sub_clk_pin from outside, and the bus idle while ce is low.
//
// Notes on behaviour
// - Demod done sets flag; needs global, own enable
// - Demod taken: clear its flag and global
// - Conversion done sets flag; needs global, enable
// - Conversion taken: clear its flag and global
// - Time-base overflow sets flag; needs both enables
// - Time-base taken: clear its flag and global
// - Source select: system, system/4, subsidiary clock
// - Time base 0 period 256 doubling to 32768
// - Time base 1 period, same scale, independent
// - Bit 7 runs each generator, resets zero
// - Unimplemented control bits always read zero
// - Nvm done sets flag; needs global, own, group2
// - Nvm taken: group flag, global cleared only
// - Low voltage sets flag; needs global, own, group2
// - Low voltage taken: source flag stays set
// - Each timer: two flags, two enables
// - Timer match sets flag via group 0/1
// - Timer taken: group flag, global cleared only
// - Serial byte sets flag; needs global, enable
// - Serial taken: clear its flag and global
// - No vectoring while return stack is full
// - Group flag set by its member requests
// - Flags set even when disabled; global blocks
`default_nettype none

module irq_sources_and_time_base (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    ce,
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire irq_tb_pkg::src_events_t events,
  input  wire logic                    stack_full,
  input  wire logic                    irq_return,
  input  wire logic                    sub_clk_pin,
  output irq_tb_pkg::vector_req_t      vector
);

  // ********************************************************
  // Bus channel state
  // ********************************************************
  logic        awready_q;
  logic        wready_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        arready_q;
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        aw_have_q;
  logic        w_have_q;
  logic [7:0]  aw_addr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  // ********************************************************
  // Register and block state
  // ********************************************************
  logic [7:0]                     tb_ctrl_q [irq_tb_pkg::N_TIMERS];
  logic [7:0]                     clk_sel_q;
  logic [irq_tb_pkg::FLAG_W-1:0]  flag_q;
  logic [irq_tb_pkg::FLAG_W-1:0]  flag_d;
  logic [irq_tb_pkg::EN_W-1:0]    en_q;
  logic [irq_tb_pkg::EN_W-1:0]    en_base;
  logic                           glob_d;
  irq_tb_pkg::vector_req_t        vector_q;
  logic [1:0]                     div4_q;
  logic                           sub_meta_q;
  logic                           sub_sync_q;
  logic                           sub_prev_q;

  // ********************************************************
  // Write path decode
  // ********************************************************
  wire aw_hs    = s_axi_awvalid & awready_q;
  wire w_hs     = s_axi_wvalid & wready_q;
  wire b_hs     = bvalid_q & s_axi_bready;
  wire ar_hs    = s_axi_arvalid & arready_q;
  wire r_hs     = rvalid_q & s_axi_rready;
  wire do_write = aw_have_q & w_have_q & ~bvalid_q;

  wire [31:0] wmask;
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_lane
      assign wmask[gb*8 +: 8] = {8{wstrb_q[gb]}};
    end
  endgenerate

  wire wa_tb0  = aw_addr_q == irq_tb_pkg::OFF_TB0_CTRL;
  wire wa_tb1  = aw_addr_q == irq_tb_pkg::OFF_TB1_CTRL;
  wire wa_clk  = aw_addr_q == irq_tb_pkg::OFF_CLK_SEL;
  wire wa_en   = aw_addr_q == irq_tb_pkg::OFF_ENABLE;
  wire wa_flg  = aw_addr_q == irq_tb_pkg::OFF_FLAGS;
  wire wa_sts  = aw_addr_q == irq_tb_pkg::OFF_STATUS;
  wire wa_hit  = wa_tb0 | wa_tb1 | wa_clk | wa_en | wa_flg | wa_sts;
  wire wr_tb0  = do_write & wa_tb0;
  wire wr_tb1  = do_write & wa_tb1;
  wire wr_clk  = do_write & wa_clk;
  wire wr_en   = do_write & wa_en;
  wire wr_flg  = do_write & wa_flg;

  wire [31:0] wmerge_tb0 = ({24'h000000, tb_ctrl_q[0]} & ~wmask)
                         | (wdata_q & wmask);
  wire [31:0] wmerge_tb1 = ({24'h000000, tb_ctrl_q[1]} & ~wmask)
                         | (wdata_q & wmask);
  wire [31:0] wmerge_clk = ({24'h000000, clk_sel_q} & ~wmask)
                         | (wdata_q & wmask);
  wire [31:0] wmerge_en  = ({16'h0000, en_q} & ~wmask)
                         | (wdata_q & wmask);
  wire [31:0] wclear     = wdata_q & wmask;

  // Only implemented bits are ever stored
  wire [7:0] tb0_new = wmerge_tb0[7:0] & irq_tb_pkg::TB_CTRL_MASK;
  wire [7:0] tb1_new = wmerge_tb1[7:0] & irq_tb_pkg::TB_CTRL_MASK;
  wire [7:0] clk_new = wmerge_clk[7:0] & irq_tb_pkg::CLK_SEL_MASK;

  // ********************************************************
  // Read path decode
  // ********************************************************
  wire ra_tb0 = s_axi_araddr == irq_tb_pkg::OFF_TB0_CTRL;
  wire ra_tb1 = s_axi_araddr == irq_tb_pkg::OFF_TB1_CTRL;
  wire ra_clk = s_axi_araddr == irq_tb_pkg::OFF_CLK_SEL;
  wire ra_en  = s_axi_araddr == irq_tb_pkg::OFF_ENABLE;
  wire ra_flg = s_axi_araddr == irq_tb_pkg::OFF_FLAGS;
  wire ra_sts = s_axi_araddr == irq_tb_pkg::OFF_STATUS;
  wire ra_hit = ra_tb0 | ra_tb1 | ra_clk | ra_en | ra_flg | ra_sts;

  wire [7:0] pend;
  wire [31:0] status_word = {22'h000000, stack_full, |pend, vector_q.sel};
  wire [31:0] rd_word =
      ra_tb0 ? {24'h000000, tb_ctrl_q[0]} :
      ra_tb1 ? {24'h000000, tb_ctrl_q[1]} :
      ra_clk ? {24'h000000, clk_sel_q} :
      ra_en  ? {16'h0000, en_q} :
      ra_flg ? {18'h00000, flag_q} :
      ra_sts ? status_word :
               irq_tb_pkg::WORD_ZERO;

  // ********************************************************
  // Time-base input clock
  // ********************************************************
  // Subsidiary clock is only sampled; it must be well below aclk/2
  wire [1:0] src_sel  = clk_sel_q[irq_tb_pkg::SRC_W-1:0];
  wire       sub_rise = sub_sync_q & ~sub_prev_q;
  wire       div4_hit = div4_q == irq_tb_pkg::DIV4_LAST;
  // Undefined code selects nothing, so both time bases hold
  wire tb_tick =
      (src_sel == irq_tb_pkg::SRC_SYS)      ? 1'b1 :
      (src_sel == irq_tb_pkg::SRC_SYS_DIV4) ? div4_hit :
      (src_sel == irq_tb_pkg::SRC_SUB)      ? sub_rise :
                                              1'b0;

  // ********************************************************
  // Time-base generators
  // ********************************************************
  wire [irq_tb_pkg::N_TIMERS-1:0] tb_ovf;
  genvar gt;
  generate
    for (gt = 0; gt < irq_tb_pkg::N_TIMERS; gt++) begin : g_tbase
      logic [irq_tb_pkg::CNT_W-1:0] cnt_q;
      wire run = tb_ctrl_q[gt][irq_tb_pkg::RUN_BIT];
      wire [irq_tb_pkg::PERIOD_W-1:0] per =
          tb_ctrl_q[gt][irq_tb_pkg::PERIOD_LSB +: irq_tb_pkg::PERIOD_W];
      // Period is 256 input clocks shifted up by the code
      wire [irq_tb_pkg::CNT_W-1:0] last =
          (irq_tb_pkg::BASE_PERIOD << per) - irq_tb_pkg::CNT_ONE;
      wire at_last = cnt_q == last;
      assign tb_ovf[gt] = run & tb_tick & at_last;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cnt_q <= irq_tb_pkg::CNT_RESET;
        end else if (ce) begin
          if (!run) begin
            cnt_q <= irq_tb_pkg::CNT_RESET;
          end else if (tb_tick) begin
            cnt_q <= at_last ? irq_tb_pkg::CNT_RESET
                             : cnt_q + irq_tb_pkg::CNT_ONE;
          end
        end
      end
    end
  endgenerate

  // ********************************************************
  // Request flags
  // ********************************************************
  wire [1:0] tmr_any = events.timer_period_match
                     | events.timer_second_match;
  wire [irq_tb_pkg::FLAG_W-1:0] flag_set;
  // Events set flags whatever the enables say
  assign flag_set[irq_tb_pkg::B_DEMOD]  = events.demod_done;
  assign flag_set[irq_tb_pkg::B_CONV]   = events.conv_done;
  assign flag_set[irq_tb_pkg::B_TB0]    = tb_ovf[0];
  assign flag_set[irq_tb_pkg::B_TB1]    = tb_ovf[1];
  assign flag_set[irq_tb_pkg::B_GRP0]   = tmr_any[0];
  assign flag_set[irq_tb_pkg::B_GRP1]   = tmr_any[1];
  assign flag_set[irq_tb_pkg::B_GRP2]   = events.nvm_write_done
                                        | events.low_voltage;
  assign flag_set[irq_tb_pkg::B_SERIAL] = events.serial_byte_done;
  assign flag_set[irq_tb_pkg::B_NVM]    = events.nvm_write_done;
  assign flag_set[irq_tb_pkg::B_LV]     = events.low_voltage;

  // Each timer owns a period-match and a second-match flag
  generate
    for (gt = 0; gt < irq_tb_pkg::N_TIMERS; gt++) begin : g_tmr_flag
      assign flag_set[irq_tb_pkg::B_TMR + 2*gt] =
          events.timer_period_match[gt];
      assign flag_set[irq_tb_pkg::B_TMR + 2*gt + 1] =
          events.timer_second_match[gt];
    end
  endgenerate

  // ********************************************************
  // Vector decision
  // ********************************************************
  wire [irq_tb_pkg::FLAG_W-1:0] live = flag_q & en_q[irq_tb_pkg::FLAG_W-1:0];
  wire grp0_src = |live[irq_tb_pkg::B_TMR +: 2];
  wire grp1_src = |live[irq_tb_pkg::B_TMR + 2 +: 2];
  wire grp2_src = live[irq_tb_pkg::B_NVM] | live[irq_tb_pkg::B_LV];
  // Group vectors also need an enabled member still requesting
  assign pend = live[irq_tb_pkg::VEC_W-1:0]
              & {1'b1, grp2_src, grp1_src, grp0_src, 4'hf};
  wire glob     = en_q[irq_tb_pkg::B_GLOBAL];
  // Held off, not dropped, while the return stack is full
  wire take     = ce & glob & |pend & ~stack_full;
  // Lowest set bit wins; the rest stay pending
  wire [7:0] take_sel = pend & (~pend + 8'h01);
  // Only the vector-order flags clear; member flags are software's
  wire [irq_tb_pkg::FLAG_W-1:0] hw_clr =
      take ? {irq_tb_pkg::NO_SRC_CLR, take_sel}
           : irq_tb_pkg::FLAG_RESET;
  wire [irq_tb_pkg::FLAG_W-1:0] sw_clr =
      wr_flg ? wclear[irq_tb_pkg::FLAG_W-1:0] : irq_tb_pkg::FLAG_RESET;
  // A new event beats any clear landing in the same cycle
  assign flag_d  = (flag_q & ~hw_clr & ~sw_clr) | flag_set;
  assign en_base = wr_en ? (wmerge_en[irq_tb_pkg::EN_W-1:0]
                            & irq_tb_pkg::EN_MASK) : en_q;
  // Software or a return re-arms; otherwise a taken vector disarms
  assign glob_d  = irq_return | (wr_en ? en_base[irq_tb_pkg::B_GLOBAL]
                                       : glob & ~take);

  // ********************************************************
  // Interrupt and time-base registers
  // ********************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= irq_tb_pkg::FLAG_RESET;
      en_q   <= irq_tb_pkg::EN_RESET;
    end else if (ce) begin
      flag_q <= flag_d;
      en_q   <= en_base;
      en_q[irq_tb_pkg::B_GLOBAL] <= glob_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vector_q.take <= 1'b0;
      vector_q.sel  <= irq_tb_pkg::VEC_NONE;
    end else if (ce) begin
      vector_q.take <= take;
      if (take) begin
        vector_q.sel <= take_sel;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tb_ctrl_q[0] <= irq_tb_pkg::REG8_RESET;
      tb_ctrl_q[1] <= irq_tb_pkg::REG8_RESET;
      clk_sel_q    <= irq_tb_pkg::REG8_RESET;
    end else if (ce) begin
      if (wr_tb0) begin
        tb_ctrl_q[0] <= tb0_new;
      end
      if (wr_tb1) begin
        tb_ctrl_q[1] <= tb1_new;
      end
      if (wr_clk) begin
        clk_sel_q <= clk_new;
      end
    end
  end

  // ********************************************************
  // Clock source helpers
  // ********************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div4_q     <= 2'h0;
      sub_meta_q <= 1'b0;
      sub_sync_q <= 1'b0;
      sub_prev_q <= 1'b0;
    end else if (ce) begin
      div4_q     <= div4_q + 2'h1;
      sub_meta_q <= sub_clk_pin;
      sub_sync_q <= sub_meta_q;
      sub_prev_q <= sub_sync_q;
    end
  end

  // ********************************************************
  // AXI4-Lite write channel
  // ********************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= 8'h00;
      wdata_q   <= irq_tb_pkg::WORD_ZERO;
      wstrb_q   <= 4'h0;
      bvalid_q  <= 1'b0;
      bresp_q   <= irq_tb_pkg::RESP_OKAY;
    end else if (ce) begin
      awready_q <= ~aw_have_q & ~aw_hs & ~bvalid_q;
      wready_q  <= ~w_have_q & ~w_hs & ~bvalid_q;
      if (aw_hs) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_hs) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wa_hit ? irq_tb_pkg::RESP_OKAY
                           : irq_tb_pkg::RESP_SLVERR;
      end
      if (b_hs) begin
        bvalid_q  <= 1'b0;
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
      end
    end
  end

  // ********************************************************
  // AXI4-Lite read channel
  // ********************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= irq_tb_pkg::WORD_ZERO;
      rresp_q   <= irq_tb_pkg::RESP_OKAY;
    end else if (ce) begin
      arready_q <= ~rvalid_q & ~ar_hs;
      if (ar_hs) begin
        rvalid_q <= 1'b1;
        rdata_q  <= rd_word;
        rresp_q  <= ra_hit ? irq_tb_pkg::RESP_OKAY
                           : irq_tb_pkg::RESP_SLVERR;
      end else if (r_hs) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign vector        = vector_q;

endmodule : irq_sources_and_time_base

`default_nettype wire

//--- core_side_model.sv
// Partner model: peripheral event sources, core stack and return.
// Assumes the bench commands it just after rising edges of aclk.
`default_nettype none
module core_side_model (
  input  wire logic                    aclk,
  input  wire irq_tb_pkg::src_events_t ev_cmd,
  input  wire logic                    full_cmd,
  input  wire logic                    ret_cmd,
  output irq_tb_pkg::src_events_t      events,
  output logic                         stack_full,
  output logic                         irq_return,
  output logic                         sub_clk
);
  timeunit 1ns;
  timeprecision 1ps;
  // Subsidiary clock, free-running and unrelated to aclk
  always begin
    sub_clk = 1'h0;
    #9;
    sub_clk = 1'h1;
    #9;
  end
  // Registered so every pulse is a whole number of aclk cycles wide
  always_ff @(posedge aclk) begin
    events     <= ev_cmd;
    stack_full <= full_cmd;
    irq_return <= ret_cmd;
  end
endmodule : core_side_model
`default_nettype wire

//--- irq_sources_and_time_base_asserts.sv
// Checker for bus answers and vector timing of the collector.
// Sees only the top-level ports; attached by the bind at the foot.
`default_nettype none
module irq_asserts (
  input wire logic                    aclk,
  input wire logic                    aresetn,
  input wire logic                    ce,
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_wready,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic                    s_axi_rvalid,
  input wire logic                    stack_full,
  input wire irq_tb_pkg::vector_req_t vector
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    ce && s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    ce && s_axi_arvalid && s_axi_arready;
  endsequence
  AST_WR_RESP: assert property (s_wr_taken ##1 ce |=> s_axi_bvalid)
    else $error("write response late");
  AST_RD_RESP: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read data late");
  AST_WR_IDLE: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write ready while response pending");
  AST_TAKE_NOFULL: assert property (
    $rose(vector.take) |-> !$past(stack_full))
    else $error("vector taken with stack full");
  AST_TAKE_PULSE: assert property (
    vector.take && ce |=> !vector.take)
    else $error("second take without global enable");
  AST_SEL_ONEHOT: assert property (
    vector.take |-> $onehot(vector.sel))
    else $error("taken vector not one-hot");
  AST_SEL_HOLD: assert property (
    !vector.take && $past(aresetn) |-> $stable(vector.sel))
    else $error("vector select moved without take");
  AST_CE_FREEZE: assert property (!ce |=> $stable(vector))
    else $error("vector moved while frozen");
endmodule : irq_asserts
bind irq_sources_and_time_base irq_asserts chk (.aclk, .aresetn, .ce,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .stack_full, .vector);
`default_nettype wire

//--- tb.sv
// Self-checking bench for the interrupt collector and time bases.
// Assumes the partner model drives events, stack level and returns.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'h0, aresetn = 1'h0, ce = 1'h1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, en;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
  logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        stack_full, irq_return, sub_clk_pin;
  logic        full_cmd = 1'h0, ret_cmd = 1'h0;
  irq_tb_pkg::src_events_t events, ev_cmd = '0;
  irq_tb_pkg::vector_req_t vector;
  logic [33:0] rd_q[$];
  logic [7:0]  vec_q[$];
  logic [1:0]  b_q[$];
  int          num_errors = 0, num_checks = 0, seed = 32'h2f6b2b7f, n;
  int          sb[9] = '{0, 1, 7, 8, 9, 10, 11, 12, 13};
  int          vb[9] = '{0, 1, 7, 6, 6, 4, 4, 5, 5};
  int          eb[9] = '{8, 7, 4, 6, 5, 2, 0, 3, 1};

  irq_sources_and_time_base uut (.aclk, .aresetn, .ce, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .events,
    .stack_full, .irq_return, .sub_clk_pin, .vector);
  core_side_model peer (.aclk, .ev_cmd, .full_cmd, .ret_cmd, .events,
    .stack_full, .irq_return, .sub_clk(sub_clk_pin));

  always #2 aclk = ~aclk;

  task automatic chk(input string nm, input logic [33:0] e, g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    // Mapped words are 0x00 to 0x14; anything else is refused
    b_q.push_back(a < 8'h18 && a[1:0] == 2'h0 ? 2'h0 : 2'h2);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    @(posedge aclk);
  endtask : wr

  // Expected word carries the response code in its top two bits
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rd_q.push_back(e);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    @(posedge aclk);
  endtask : rd

  task automatic pulse(input irq_tb_pkg::src_events_t e);
    ev_cmd <= e;
    @(posedge aclk);
    ev_cmd <= '0;
    @(posedge aclk);
  endtask : pulse

  // Also ends any return pulse raised just before the call
  task automatic wait_take();
    n = 0;
    do begin
      @(posedge aclk);
      ret_cmd <= 1'h0;
      n++;
    end while (vector.take !== 1'h1 && n < 40000);
    chk("vector_take", 34'h1, vector.take);
  endtask : wait_take

  task automatic tb_run(input logic [7:0] a, input logic [31:0] ctl,
                        input logic [1:0] src, input int per);
    wr(8'h08, {30'h0, src});
    wr(8'h0c, 32'h8000 | (32'h4 << a[2]));
    vec_q.push_back(8'h4 << a[2]);
    vec_q.push_back(8'h4 << a[2]);
    wr(a, ctl);
    wait_take();
    ret_cmd <= 1'h1;
    wait_take();
    if (per > 0) chk("tb_period", per, n);
    wr(a, 32'h0);
    rd(8'h10, 32'h0);
  endtask : tb_run

  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready)
      chk("rdata", rd_q.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready)
      chk("bresp", b_q.pop_front(), s_axi_bresp);
    if (vector.take === 1'h1)
      chk("vector_sel", vec_q.size() > 0 ? vec_q.pop_front() : 8'hff,
          vector.sel);
  end

  initial begin
    repeat (90000) @(posedge aclk);
    num_errors++;
    test_done();
  end

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    ce      <= 1'h0;
    repeat (4) @(posedge aclk);
    ce <= 1'h1;
    @(posedge aclk);
    for (int i = 0; i < 5; i++) rd(8'(4 * i), 34'h0);
    rd(8'h18, 34'h2_0000_0000);
    wr(8'h18, 32'h0);
    for (int i = 0; i < 3; i++) begin
      d = $random(seed);
      wr(8'(4 * i), d);
      rd(8'(4 * i), d & (i == 2 ? 8'h03 : 8'h87));
      wr(8'(4 * i), 32'h0);
    end
    // Every event source through its own or its shared vector
    for (int i = 0; i < 9; i++) begin
      en = 32'h8000 | (32'h1 << sb[i]) | (32'h1 << vb[i]);
      wr(8'h0c, en);
      vec_q.push_back(8'h1 << vb[i]);
      pulse(9'h1 << eb[i]);
      wait_take();
      rd(8'h10, sb[i] == vb[i] ? 32'h0 : 32'h1 << sb[i]);
      rd(8'h0c, en & 32'h7fff);
      wr(8'h10, 32'h3fff);
    end
    wr(8'h0c, 32'h8000);
    pulse(9'h100);
    rd(8'h10, 32'h1);
    full_cmd <= 1'h1;
    wr(8'h0c, 32'h8003);
    pulse(9'h080);
    rd(8'h14, 34'h320);
    repeat (20) @(posedge aclk);
    vec_q.push_back(8'h01);
    full_cmd <= 1'h0;
    wait_take();
    vec_q.push_back(8'h02);
    ret_cmd <= 1'h1;
    wait_take();
    rd(8'h14, 34'h2);
    tb_run(8'h00, 32'h80, 2'h0, 256);
    tb_run(8'h04, 32'h81, 2'h0, 512);
    tb_run(8'h00, 32'h80, 2'h1, 1024);
    tb_run(8'h04, 32'h80, 2'h3, 0);
    tb_run(8'h00, 32'h87, 2'h0, 32768);
    wr(8'h08, 32'h2);
    wr(8'h0c, 32'h8004);
    wr(8'h00, 32'h80);
    repeat (700) @(posedge aclk);
    rd(8'h10, 32'h0);
    wr(8'h00, 32'h0);
    test_done();
  end
endmodule : tb
`default_nettype wire
